// [mag_cfg_asserts.sv]
// Port checks on the measurement and gain configuration bank.
// Assumes it is bound onto magnetometer_measurement_config.
`timescale 1ns/1ps
`default_nettype none
module mag_cfg_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        wrStrobe,
    input wire logic        rdStrobe,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  wrData,
    input wire logic        measDone,
    input wire logic [7:0]  rdData,
    input wire logic        tempSenseEnable,
    input wire logic [3:0]  avgCount,
    input wire logic [2:0]  outputRateSel,
    input wire logic        biasPosOe,
    input wire logic        biasNegOe,
    input wire logic        magSensorEnable,
    input wire logic [2:0]  gainSel,
    input wire logic [10:0] gainCountsPerGauss,
    input wire logic        measStart,
    input wire logic        resultReady
);
    logic [7:0]  wd1, wd2;    // Write data delayed to match decode lag
    logic [10:0] gtab [0:7] = '{11'h55a, 11'h442, 11'h334, 11'h294,
                                11'h1b8, 11'h186, 11'h14a, 11'h0e6};
    wire         meas0 = wrStrobe && regAddr == 8'h00;
    // Pipeline: decoded outputs trail a write by two edges
    always @(posedge clk)
    begin
        wd1 <= wrData;
        wd2 <= wd1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_temp;
        meas0 |-> ##2 tempSenseEnable == (wd2[7] || wd2[1:0] == 2'h3);
    endproperty
    a_temp: assert property (p_temp) else $error("temp enable wrong");
    property p_avg;
        meas0 |-> ##2 avgCount == (4'h1 << wd2[6:5]);
    endproperty
    a_avg: assert property (p_avg) else $error("avg count wrong");
    property p_rate;
        meas0 |-> ##2 outputRateSel == wd2[4:2];
    endproperty
    a_rate: assert property (p_rate) else $error("rate code wrong");
    property p_bias;
        meas0 |-> ##2 biasPosOe == (wd2[1:0] == 2'h1)
                   && biasNegOe == (wd2[1:0] == 2'h2);
    endproperty
    a_bias: assert property (p_bias) else $error("bias wrong");
    property p_mag;
        meas0 |-> ##2 magSensorEnable == (wd2[1:0] != 2'h3);
    endproperty
    a_mag: assert property (p_mag) else $error("mag enable wrong");
    property p_rdz;
        rdStrobe && regAddr > 8'h01 |=> rdData == 8'h00;
    endproperty
    a_rdz: assert property (p_rdz) else $error("bad address read");
    property p_gmap;
        gainCountsPerGauss == gtab[$past(gainSel)];
    endproperty
    a_gmap: assert property (p_gmap) else $error("gain value wrong");
    // Gain may only move on a finished measurement
    property p_ghold;
        $changed(gainSel) |-> $past(measDone);
    endproperty
    a_ghold: assert property (p_ghold) else $error("gain early");
    property p_rdy;
        resultReady |-> measStart ##1 !resultReady;
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready pulse wrong");
endmodule // mag_cfg_asserts
bind magnetometer_measurement_config mag_cfg_asserts chk (
    .clk(clk), .sys_rst(sys_rst), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .regAddr(regAddr), .wrData(wrData),
    .measDone(measDone), .rdData(rdData),
    .tempSenseEnable(tempSenseEnable), .avgCount(avgCount),
    .outputRateSel(outputRateSel), .biasPosOe(biasPosOe),
    .biasNegOe(biasNegOe), .magSensorEnable(magSensorEnable),
    .gainSel(gainSel), .gainCountsPerGauss(gainCountsPerGauss),
    .measStart(measStart), .resultReady(resultReady));
`default_nettype wire

// [mag_cfg_regs.vh]
// Constants for the magnetometer measurement and gain configuration bank.
// Assumes inclusion by bare name from files in the same folder.
`ifndef MAG_CFG_REGS_VH
`define MAG_CFG_REGS_VH

// --------------------------------------------------------------------
// Register locations on the serial register pointer
// --------------------------------------------------------------------
`define MEAS_CFG_ADDR      8'h00
`define GAIN_CFG_ADDR      8'h01

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define MEAS_CFG_RESET     8'h10
`define GAIN_CFG_RESET     8'h20

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define TEMP_EN_BIT        7
`define AVG_MSB            6
`define AVG_LSB            5
`define RATE_MSB           4
`define RATE_LSB           2
`define FLOW_MSB           1
`define FLOW_LSB           0
`define GAIN_MSB           7
`define GAIN_LSB           5
`define GAIN_WR_MASK       8'he0

// --------------------------------------------------------------------
// Measurement flow codes
// --------------------------------------------------------------------
`define FLOW_NORMAL        2'h0
`define FLOW_POS_BIAS      2'h1
`define FLOW_NEG_BIAS      2'h2
`define FLOW_TEMP_ONLY     2'h3

// --------------------------------------------------------------------
// Output periods at 40 MHz, in clock cycles, one per rate code
// --------------------------------------------------------------------
`define CLK_HZ             40000000
`define PER_0P75HZ         32'd53333333
`define PER_1P5HZ          32'd26666666
`define PER_3HZ            32'd13333333
`define PER_7P5HZ          32'd5333333
`define PER_15HZ           32'd2666666
`define PER_30HZ           32'd1333333
`define PER_75HZ           32'd533333
`define PER_220HZ          32'd181818

`endif

// [magnetometer_measurement_config.v]
// Measurement and gain configuration registers with the measurement
// sequencing controls they steer. Assumes a serial front end that
// has already deframed bytes (msb first) into address/data strobes.
`timescale 1ns/1ps
`default_nettype none
`include "mag_cfg_regs.vh"

module magnetometer_measurement_config #(
    parameter integer PERIOD_SCALE = 1       // Shortens periods in sim
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        wrStrobe,             // Byte write from host port
    input  wire        rdStrobe,             // Byte read from host port
    input  wire [7:0]  regAddr,              // Register pointer
    input  wire [7:0]  wrData,               // Deframed byte, bit 7 first
    input  wire        continuousMode,       // Mode is continuous
    input  wire        measDone,             // Sequencer finished one
    output reg  [7:0]  rdData,               // Read byte
    output reg         tempSenseEnable,      // Temperature measured too
    output reg  [3:0]  avgCount,             // Samples per output
    output reg  [2:0]  outputRateSel,        // Rate code
    output reg         biasPosOe,            // Drive positive bias
    output reg         biasNegOe,            // Drive negative bias
    output reg         magSensorEnable,      // Magnetic path on
    output reg         tempCompEnable,       // Apply compensation
    output reg  [2:0]  gainSel,              // Gain applied to X,Y,Z
    output reg  [10:0] gainCountsPerGauss,   // Nominal gain value
    output reg         measStart,            // Start three-axis set
    output reg         resultReady           // Full set presented
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg  [7:0] measCfg_reg;                  // Measurement config
    reg  [7:0] gainCfg_reg;                  // Gain config
    reg  [2:0] gainPend_reg;                 // Written gain, waiting
    reg  [1:0] gainLag_reg;                  // Measurements to wait
    reg  [1:0] settle_reg;                   // Periods before first set
    reg        busy_reg;                     // Set in progress
    reg        restart_reg;                  // Timer restart pulse

    wire       periodTick;                   // End of output period
    wire       cfgWrite = wrStrobe &&
                 (regAddr == `MEAS_CFG_ADDR || regAddr == `GAIN_CFG_ADDR);

    // ----------------------------------------------------------------
    // Gain lookup, counts per gauss
    // ----------------------------------------------------------------
    function [10:0] gainValue;
        input [2:0] code;
        begin
            case (code)
                3'h0:    gainValue = 11'd1370;
                3'h1:    gainValue = 11'd1090;
                3'h2:    gainValue = 11'd820;
                3'h3:    gainValue = 11'd660;
                3'h4:    gainValue = 11'd440;
                3'h5:    gainValue = 11'd390;
                3'h6:    gainValue = 11'd330;
                default: gainValue = 11'd230;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Period timer, restarted by any configuration write
    // ----------------------------------------------------------------
    rate_divider #(
        .SCALE      (PERIOD_SCALE)
    ) u_rate (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .restart    (restart_reg),
        .rateSel    (measCfg_reg[`RATE_MSB:`RATE_LSB]),
        .periodTick (periodTick)
    );

    // ----------------------------------------------------------------
    // Register writes; only the gain field of the gain register is
    // kept, so low bits always read zero whatever the host sends
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            measCfg_reg  <= `MEAS_CFG_RESET;
            gainCfg_reg  <= `GAIN_CFG_RESET;
            restart_reg  <= 1'b0;
        end
        else
        begin
            restart_reg <= cfgWrite;
            if (wrStrobe && regAddr == `MEAS_CFG_ADDR)
                measCfg_reg <= wrData;
            else if (wrStrobe && regAddr == `GAIN_CFG_ADDR)
                gainCfg_reg <= wrData & `GAIN_WR_MASK;
        end
    end

    // ----------------------------------------------------------------
    // Read mux; unknown locations answer zero
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            rdData <= 8'h00;
        else if (rdStrobe)
        begin
            case (regAddr)
                `MEAS_CFG_ADDR: rdData <= measCfg_reg;
                `GAIN_CFG_ADDR: rdData <= gainCfg_reg;
                default:        rdData <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Gain pipeline: the measurement already under way, or the next
    // one, still uses the old gain; the new one lands after that
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gainSel      <= 3'h1;
            gainPend_reg <= 3'h1;
            gainLag_reg  <= 2'h0;
        end
        else if (wrStrobe && regAddr == `GAIN_CFG_ADDR)
        begin
            gainPend_reg <= wrData[`GAIN_MSB:`GAIN_LSB];
            gainLag_reg  <= 2'h1;
        end
        else if (measDone && gainLag_reg != 2'h0)
        begin
            gainLag_reg <= gainLag_reg - 2'h1;
            gainSel     <= gainPend_reg;
        end
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            gainCountsPerGauss <= 11'd1090;
        else
            gainCountsPerGauss <= gainValue(gainSel);
    end

    // ----------------------------------------------------------------
    // Field decode to sequencer controls
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tempSenseEnable <= 1'b0;
            avgCount        <= 4'h1;
            outputRateSel   <= 3'h4;
            biasPosOe       <= 1'b0;
            biasNegOe       <= 1'b0;
            magSensorEnable <= 1'b1;
            tempCompEnable  <= 1'b0;
        end
        else
        begin
            tempSenseEnable <= measCfg_reg[`TEMP_EN_BIT]
                || measCfg_reg[`FLOW_MSB:`FLOW_LSB] == `FLOW_TEMP_ONLY;
            tempCompEnable  <= measCfg_reg[`TEMP_EN_BIT];
            avgCount        <= 4'h1 <<
                               measCfg_reg[`AVG_MSB:`AVG_LSB];
            outputRateSel   <= measCfg_reg[`RATE_MSB:`RATE_LSB];
            case (measCfg_reg[`FLOW_MSB:`FLOW_LSB])
                `FLOW_POS_BIAS:
                begin
                    biasPosOe       <= 1'b1;
                    biasNegOe       <= 1'b0;
                    magSensorEnable <= 1'b1;
                end
                `FLOW_NEG_BIAS:
                begin
                    biasPosOe       <= 1'b0;
                    biasNegOe       <= 1'b1;
                    magSensorEnable <= 1'b1;
                end
                `FLOW_TEMP_ONLY:
                begin
                    biasPosOe       <= 1'b0;
                    biasNegOe       <= 1'b0;
                    magSensorEnable <= 1'b0;
                end
                default:
                begin
                    biasPosOe       <= 1'b0;
                    biasNegOe       <= 1'b0;
                    magSensorEnable <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Continuous sequencing: each period starts one three-axis set;
    // results show only once the whole set is done. After a write the
    // first period is dropped so the first set lands at two periods.
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            settle_reg  <= 2'h1;
            busy_reg    <= 1'b0;
            measStart   <= 1'b0;
            resultReady <= 1'b0;
        end
        else
        begin
            measStart   <= 1'b0;
            resultReady <= 1'b0;
            // The timer restarts a cycle after the write; a tick that
            // lands in that cycle must not count toward the settling
            if (cfgWrite || restart_reg || !continuousMode)
            begin
                settle_reg <= 2'h1;
                busy_reg   <= 1'b0;
            end
            else if (periodTick)
            begin
                if (settle_reg != 2'h0)
                begin
                    settle_reg <= settle_reg - 2'h1;
                    measStart  <= 1'b1;
                    busy_reg   <= 1'b1;
                end
                else
                begin
                    resultReady <= ~busy_reg;
                    measStart   <= 1'b1;
                    busy_reg    <= 1'b1;
                end
            end
            else if (measDone && busy_reg && settle_reg == 2'h0)
                busy_reg <= 1'b0;
        end
    end

endmodule // magnetometer_measurement_config

`default_nettype wire

// [meas_seq_model.sv]
// Behavioural stand-in for the three-axis measurement sequencer.
// Assumes start pulses come from the configuration bank.
`timescale 1ns/1ps
`default_nettype none
module meas_seq_model (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       measStart,   // Start of a three-axis set
    input  wire logic [3:0] lat,         // Extra cycles per set
    output var  logic       measDone     // Set finished pulse
);
    logic [4:0] cntReg;                  // Cycles left in running set
    // At most one done pulse per start; a new start restarts the set
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cntReg   <= 5'h00;
            measDone <= 1'b0;
        end
        else
        begin
            measDone <= (cntReg == 5'h01);
            if (measStart)
                cntReg <= {1'b0, lat} + 5'h01;
            else if (cntReg != 5'h00)
                cntReg <= cntReg - 5'h01;
        end
    end
endmodule // meas_seq_model
`default_nettype wire

// [rate_divider.v]
// Output period timer: counts a period selected by the rate code.
// Assumes restart is a same-clock pulse from the configuration block.
`timescale 1ns/1ps
`default_nettype none
`include "mag_cfg_regs.vh"

module rate_divider #(
    parameter integer SCALE = 1             // Divides every period
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       restart,               // Restart period count
    input  wire [2:0] rateSel,               // Rate code
    output reg        periodTick             // One pulse per period
);

    // ----------------------------------------------------------------
    // Period lookup
    // ----------------------------------------------------------------
    function [31:0] periodOf;
        input [2:0] code;
        begin
            case (code)
                3'h0:    periodOf = `PER_0P75HZ;
                3'h1:    periodOf = `PER_1P5HZ;
                3'h2:    periodOf = `PER_3HZ;
                3'h3:    periodOf = `PER_7P5HZ;
                3'h4:    periodOf = `PER_15HZ;
                3'h5:    periodOf = `PER_30HZ;
                3'h6:    periodOf = `PER_75HZ;
                default: periodOf = `PER_220HZ;
            endcase
        end
    endfunction

    wire [31:0] limit = (periodOf(rateSel) / SCALE) + 32'd0; // Scaled
    reg  [31:0] count_reg;                   // Cycles into period

    // ----------------------------------------------------------------
    // Counter; never below one cycle per period
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_reg  <= 32'h0;
            periodTick <= 1'b0;
        end
        else if (restart)
        begin
            count_reg  <= 32'h0;
            periodTick <= 1'b0;
        end
        else if (count_reg + 32'd1 >= limit)
        begin
            count_reg  <= 32'h0;
            periodTick <= 1'b1;
        end
        else
        begin
            count_reg  <= count_reg + 32'd1;
            periodTick <= 1'b0;
        end
    end

endmodule // rate_divider

`default_nettype wire

// [tb.sv]
// Self-checking bench for the configuration bank and its timing.
// Assumes the sequencer model answers each start pulse that is not cut short by the next one.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int P = 181818 / 20000;   // 220 Hz period, scaled
    logic clk, sysRst, wrStrobe, rdStrobe, continuousMode, rdSeen;
    logic [7:0] regAddr, wrData, v, rdData;
    logic [3:0] lat, avgCount;
    logic [2:0] outputRateSel, gainSel, prevG;
    logic [10:0] gainCountsPerGauss;
    logic measDone, tempSenseEnable, biasPosOe, biasNegOe;
    logic magSensorEnable, tempCompEnable, measStart, resultReady;
    logic [31:0] rnd = 32'h73b9;         // Fixed seed
    logic [7:0] expQ [$];                // Expected read bytes
    logic [10:0] gtab [0:7] = '{11'h55a, 11'h442, 11'h334, 11'h294,
                                11'h1b8, 11'h186, 11'h14a, 11'h0e6};
    int num_errors = 0, comparisons = 0, n, m, starts = 0;
    magnetometer_measurement_config #(.PERIOD_SCALE(20000)) dut (
        .clk(clk), .sys_rst(sysRst), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .regAddr(regAddr), .wrData(wrData),
        .continuousMode(continuousMode), .measDone(measDone),
        .rdData(rdData), .tempSenseEnable(tempSenseEnable),
        .avgCount(avgCount), .outputRateSel(outputRateSel),
        .biasPosOe(biasPosOe), .biasNegOe(biasNegOe),
        .magSensorEnable(magSensorEnable),
        .tempCompEnable(tempCompEnable), .gainSel(gainSel),
        .gainCountsPerGauss(gainCountsPerGauss),
        .measStart(measStart), .resultReady(resultReady));
    meas_seq_model seq (.clk(clk), .sys_rst(sysRst),
        .measStart(measStart), .lat(lat), .measDone(measDone));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        #2;
        wrStrobe = w;
        rdStrobe = !w;
        regAddr = a;
        wrData = d;
        if (!w)
            expQ.push_back(d);
        @(posedge clk);
        #2;
        wrStrobe = 0;
        rdStrobe = 0;
    endtask
    // Bounded wait; sel picks measDone or resultReady
    task automatic waitSig(input logic sel, output int k);
        k = 0;
        while (!(sel ? measDone : resultReady) && k < 200)
        begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Read checker: a byte lands one edge after its strobe; also
    // counts start pulses so idle phases can be held to none
    always @(posedge clk)
    begin
        if (rdSeen)
            chk(rdData, expQ.pop_front());
        rdSeen <= rdStrobe;
        if (measStart)
            starts <= starts + 1;
    end
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        #500000;
        num_errors++;
        summarize();
    end
    initial
    begin
        {sysRst, rdSeen, wrStrobe, rdStrobe, continuousMode} = 5'h10;
        {regAddr, wrData, lat} = 20'h00002;
        repeat (5) @(posedge clk);
        #2 sysRst = 0;
        bus(1, 8'h31, 8'hff);
        bus(0, 8'h00, 8'h10);
        bus(0, 8'h01, 8'h20);
        bus(0, 8'h02, 8'h00);
        bus(0, 8'h31, 8'h00);
        chk(gainCountsPerGauss, 11'h442);
        $display("reset test done");
        // Every rate, averaging and flow code, random temperature bit
        for (int i = 0; i < 8; i++)
        begin
            rnd = lfsr(rnd);
            v = {rnd[0], i[1:0], i[2:0], i[1:0]};
            bus(1, 8'h00, v);
            repeat (2) @(posedge clk);
            #1;
            chk(tempSenseEnable, v[7] || v[1:0] == 2'h3);
            chk(tempCompEnable, v[7]);
            chk(avgCount, 4'h1 << v[6:5]);
            chk(outputRateSel, v[4:2]);
            chk({biasPosOe, biasNegOe, magSensorEnable},
                {v[1:0] == 2'h1, v[1:0] == 2'h2, v[1:0] != 2'h3});
            bus(0, 8'h00, v);
        end
        $display("config test done");
        chk(starts, 0);
        continuousMode = 1;
        bus(1, 8'h00, 8'h1c);
        waitSig(0, n);
        chk(n >= 2 * P && n <= 2 * P + 3, 1);
        @(posedge clk);
        #1;
        waitSig(0, m);
        chk(m + 1, P);
        // Sets that outlast the period must never be presented
        lat = 4'hf;
        @(posedge clk);
        #1;
        waitSig(0, n);
        @(posedge clk);
        #1;
        waitSig(0, m);
        chk(m, 200);
        $display("timing test done");
        prevG = 3'h1;
        // After setting code 0, step gain down one code at a time, as a host does on overflow
        for (int g = 0; g < 8; g++)
        begin
            rnd = lfsr(rnd);
            lat = {1'b0, rnd[2:0]};
            bus(1, 8'h01, {g[2:0], 5'h00});
            waitSig(1, n);
            chk(gainSel, prevG);
            @(posedge clk);
            #1;
            chk(gainSel, g[2:0]);
            @(posedge clk);
            #1;
            chk(gainCountsPerGauss, gtab[g]);
            bus(0, 8'h01, {g[2:0], 5'h00});
            prevG = g[2:0];
        end
        $display("gain test done");
        @(posedge clk);
        #2 sysRst = 1;
        @(posedge clk);
        #2 sysRst = 0;
        bus(0, 8'h00, 8'h10);
        bus(0, 8'h01, 8'h20);
        repeat (2) @(posedge clk);
        chk(expQ.size(), 0);
        chk(gainCountsPerGauss, 11'h442);
        $display("second reset test done");
        summarize();
    end
endmodule // tb
`default_nettype wire
